// [sbcsup_pin_logic.sv]
// Summary of operation
// - txd low drives bus dominant, high recessive
// - rxd low on dominant bus, high recessive
// - flag temperature pre-warning above warning threshold
// - main regulator off above shutdown temperature
// - regulator undervoltage outside sleep holds reset output low
// - reset low in reset mode, else high
// - enabled pending source holds interrupt low
// - stop-mode wake gives short interrupt low pulse
// - watchdog fault output low on bad service
// - window or timeout watchdog, host configures
// - bad service asserts fault and reset together
// - battery fail recorded, battery low warns
// - wake inputs readable, changes wake sleep/stop
// - host selects operating mode by register write
// - host configures CAN interface mode
// - all timing derived from internal clock
// - inputs sampled, outputs updated on matching edges
// - reset held for reset duration after supply
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`default_nettype none

module sbcsup_pin_logic #(
    parameter int unsigned RST_DUR_CYC = sbcsup_pkg::RST_DUR_CYC,
    parameter int unsigned WD_BASE_CYC = sbcsup_pkg::WD_BASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic canTxd,
    input wire logic canBusDominant,
    input wire logic vddUnderVolt,
    input wire logic tempWarnHot,
    input wire logic tempShutdownHot,
    input wire logic batterySupplyFail,
    input wire logic batterySupplyLow,
    input wire logic [3:0] wakeInputs,
    output logic canDriveDominant,
    output logic canRxd,
    output logic resetOutLow,
    output logic interruptOutN,
    output logic watchdogFaultN,
    output logic mainRegEnable,
    output logic auxRegulatorDrive
);
    typedef struct packed {
        sbcsup_pkg::sbcsup_mode_t mode;
        logic [23:0] rstCnt;
        logic [23:0] wdCnt;
        logic [7:0] pulseCnt;
        logic wdWindow;
        logic [1:0] wdSel;
        logic [3:0] intEn;
        logic [3:0] flags;
        sbcsup_pkg::sbcsup_can_t canMode;
        logic [3:0] wakePrev;
        logic tempWarnPrev;
        logic wdFault;
        logic ackQ;
        logic [31:0] datQ;
        logic rstOut;
        logic intOutN;
        logic canDom;
        logic rxd;
        logic regEn;
        logic auxDrv;
    } sbcsup_core_t;

    sbcsup_core_t state_q;
    sbcsup_core_t state_d;

    sbcsup_pin_if pinBus ();

    logic [3:0] wakeF;
    logic vddUvF;
    logic tempWarnF;
    logic tempShutF;
    logic batFailF;
    logic batLowF;
    logic txdF;
    logic busDomF;
    logic wbReq;
    logic wbWr;
    logic modeWr;
    logic wdTrig;
    logic wakeEvt;
    logic wdActive;
    logic [3:0] flagSet;
    logic [3:0] flagClr;
    logic [23:0] wdPeriod;
    logic [31:0] rdData;
    sbcsup_pkg::sbcsup_mode_t reqMode;

    // every status, wake and CAN pin passes the three-stage filter; the bus inputs do not
    assign pinBus.raw[sbcsup_pkg::PIN_WAKE_LSB +: 4] = wakeInputs;
    assign pinBus.raw[sbcsup_pkg::PIN_VDDUV] = vddUnderVolt;
    assign pinBus.raw[sbcsup_pkg::PIN_TWARN] = tempWarnHot;
    assign pinBus.raw[sbcsup_pkg::PIN_TSHUT] = tempShutdownHot;
    assign pinBus.raw[sbcsup_pkg::PIN_BFAIL] = batterySupplyFail;
    assign pinBus.raw[sbcsup_pkg::PIN_BLOW] = batterySupplyLow;
    assign pinBus.raw[sbcsup_pkg::PIN_TXD] = canTxd;
    assign pinBus.raw[sbcsup_pkg::PIN_BUSDOM] = canBusDominant;

    sbcsup_pin_filter u_filter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pins(pinBus)
    );

    assign wakeF = pinBus.filt[sbcsup_pkg::PIN_WAKE_LSB +: 4];
    assign vddUvF = pinBus.filt[sbcsup_pkg::PIN_VDDUV];
    assign tempWarnF = pinBus.filt[sbcsup_pkg::PIN_TWARN];
    assign tempShutF = pinBus.filt[sbcsup_pkg::PIN_TSHUT];
    assign batFailF = pinBus.filt[sbcsup_pkg::PIN_BFAIL];
    assign batLowF = pinBus.filt[sbcsup_pkg::PIN_BLOW];
    assign txdF = pinBus.filt[sbcsup_pkg::PIN_TXD];
    assign busDomF = pinBus.filt[sbcsup_pkg::PIN_BUSDOM];

    // bus strobes: writes land on the acknowledging edge
    assign wbReq = cyc_i & stb_i;
    assign wbWr = wbReq & we_i & sel_i[0] & state_q.ackQ;
    assign modeWr = wbWr && (adr_i == sbcsup_pkg::ADR_MODE);
    assign wdTrig = wbWr && (adr_i == sbcsup_pkg::ADR_WDTRIG);
    assign flagClr = (wbWr && (adr_i == sbcsup_pkg::ADR_INTFLAG)) ? dat_i[3:0] : 4'h0;

    // requested mode from the written code
    assign reqMode = (dat_i[1:0] == sbcsup_pkg::REQ_NORMAL) ? sbcsup_pkg::MODE_NORMAL :
                     (dat_i[1:0] == sbcsup_pkg::REQ_STANDBY) ? sbcsup_pkg::MODE_STANDBY :
                     (dat_i[1:0] == sbcsup_pkg::REQ_STOP) ? sbcsup_pkg::MODE_STOP :
                     sbcsup_pkg::MODE_SLEEP;

    // wake input changes count only in low-power modes
    assign wakeEvt = (wakeF != state_q.wakePrev) &&
                     (state_q.mode == sbcsup_pkg::MODE_STOP || state_q.mode == sbcsup_pkg::MODE_SLEEP);
    assign wdActive = (state_q.mode == sbcsup_pkg::MODE_NORMAL) || (state_q.mode == sbcsup_pkg::MODE_STANDBY);
    assign wdPeriod = 24'(WD_BASE_CYC) << state_q.wdSel;

    // sticky event sources
    assign flagSet[sbcsup_pkg::FLG_TEMP] = tempWarnF & ~state_q.tempWarnPrev;
    assign flagSet[sbcsup_pkg::FLG_BATLOW] = batLowF & wdActive;
    assign flagSet[sbcsup_pkg::FLG_WAKE] = wakeEvt;
    assign flagSet[sbcsup_pkg::FLG_BATFAIL] = batFailF;

    // read multiplexer
    always_comb begin
        rdData = 32'h00000000;
        case (adr_i)
            sbcsup_pkg::ADR_MODE: rdData[2:0] = state_q.mode;
            sbcsup_pkg::ADR_WDCFG: begin
                rdData[sbcsup_pkg::WDCFG_WINDOW_BIT] = state_q.wdWindow;
                rdData[sbcsup_pkg::WDCFG_SEL_LSB +: 2] = state_q.wdSel;
            end
            sbcsup_pkg::ADR_INTEN: rdData[3:0] = state_q.intEn;
            sbcsup_pkg::ADR_INTFLAG: rdData[3:0] = state_q.flags;
            sbcsup_pkg::ADR_STATUS: begin
                rdData[sbcsup_pkg::ST_WAKE_LSB +: 4] = wakeF;
                rdData[sbcsup_pkg::ST_TWARN_BIT] = tempWarnF;
                rdData[sbcsup_pkg::ST_BLOW_BIT] = batLowF;
                rdData[sbcsup_pkg::ST_VDDUV_BIT] = vddUvF;
                rdData[sbcsup_pkg::ST_WDFAULT_BIT] = state_q.wdFault;
            end
            sbcsup_pkg::ADR_CANCFG: rdData[1:0] = state_q.canMode;
            default: rdData = 32'h00000000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        state_d = state_q;
        state_d.ackQ = wbReq & ~state_q.ackQ;
        if (wbReq && !state_q.ackQ) begin
            state_d.datQ = rdData;
        end
        state_d.wakePrev = wakeF;
        state_d.tempWarnPrev = tempWarnF;
        state_d.flags = (state_q.flags & ~flagClr) | flagSet; // set wins over clear
        state_d.wdCnt = 24'h000000;
        state_d.pulseCnt = (state_q.pulseCnt != 8'h00) ? state_q.pulseCnt - 8'h01 : 8'h00;

        // configuration writes
        if (wbWr) begin
            case (adr_i)
                sbcsup_pkg::ADR_WDCFG: begin
                    state_d.wdWindow = dat_i[sbcsup_pkg::WDCFG_WINDOW_BIT];
                    state_d.wdSel = dat_i[sbcsup_pkg::WDCFG_SEL_LSB +: 2];
                end
                sbcsup_pkg::ADR_INTEN: state_d.intEn = dat_i[3:0];
                sbcsup_pkg::ADR_CANCFG: state_d.canMode = sbcsup_pkg::sbcsup_can_t'(dat_i[1:0]);
                default: state_d.intEn = state_q.intEn;
            endcase
        end

        // operating mode sequencing
        case (state_q.mode)
            sbcsup_pkg::MODE_RESET: begin
                if (state_q.rstCnt == 24'(RST_DUR_CYC - 1)) begin
                    state_d.mode = sbcsup_pkg::MODE_NREQ;
                    state_d.rstCnt = 24'h000000;
                end else begin
                    state_d.rstCnt = state_q.rstCnt + 24'h000001;
                end
            end
            sbcsup_pkg::MODE_NREQ: begin
                if (modeWr && (reqMode == sbcsup_pkg::MODE_NORMAL || reqMode == sbcsup_pkg::MODE_STANDBY)) begin
                    state_d.mode = reqMode;
                end
            end
            sbcsup_pkg::MODE_NORMAL, sbcsup_pkg::MODE_STANDBY: begin
                if (modeWr) begin
                    state_d.mode = reqMode;
                end
                if (wdTrig) begin
                    if (state_q.wdWindow && (state_q.wdCnt < (wdPeriod >> 1))) begin
                        state_d.wdFault = 1'b1;
                    end else begin
                        state_d.wdFault = 1'b0;
                    end
                end else if (state_q.wdCnt >= wdPeriod - 24'h000001) begin
                    state_d.wdFault = 1'b1;
                end else begin
                    state_d.wdCnt = state_q.wdCnt + 24'h000001;
                end
                if (state_d.wdFault && (wdTrig || state_q.wdCnt >= wdPeriod - 24'h000001)) begin
                    state_d.mode = sbcsup_pkg::MODE_RESET;
                    state_d.rstCnt = 24'h000000;
                end
            end
            sbcsup_pkg::MODE_STOP: begin
                if (wakeEvt) begin
                    state_d.mode = sbcsup_pkg::MODE_NREQ;
                    state_d.pulseCnt = 8'(sbcsup_pkg::WAKE_PULSE_CYC);
                end
            end
            sbcsup_pkg::MODE_SLEEP: begin
                if (wakeEvt) begin
                    state_d.mode = sbcsup_pkg::MODE_RESET;
                    state_d.rstCnt = 24'h000000;
                end
            end
            default: state_d.mode = sbcsup_pkg::MODE_RESET;
        endcase

        // regulator undervoltage outside sleep mode forces and holds reset mode
        if (vddUvF && state_q.mode != sbcsup_pkg::MODE_SLEEP) begin
            state_d.mode = sbcsup_pkg::MODE_RESET;
            state_d.rstCnt = 24'h000000;
        end

        // pin outputs, all registered
        state_d.rstOut = (state_d.mode != sbcsup_pkg::MODE_RESET);
        state_d.intOutN = ~((|(state_d.flags & state_d.intEn)) | (state_d.pulseCnt != 8'h00));
        state_d.regEn = (state_d.mode != sbcsup_pkg::MODE_SLEEP) && !tempShutF;
        state_d.auxDrv = (state_d.mode == sbcsup_pkg::MODE_NORMAL);
        state_d.canDom = (state_d.mode == sbcsup_pkg::MODE_NORMAL) &&
                         (state_d.canMode == sbcsup_pkg::CAN_NORMAL) && !txdF;
        state_d.rxd = !((state_d.canMode != sbcsup_pkg::CAN_OFF) && busDomF);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '{mode: sbcsup_pkg::MODE_RESET, canMode: sbcsup_pkg::CANCFG_RST,
                         intEn: sbcsup_pkg::INTEN_RST, wdWindow: sbcsup_pkg::WDCFG_WINDOW_RST,
                         wdSel: sbcsup_pkg::WDCFG_SEL_RST, intOutN: 1'b1, rxd: 1'b1,
                         regEn: 1'b1, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign dat_o = state_q.datQ;
    assign ack_o = state_q.ackQ;
    assign resetOutLow = state_q.rstOut;
    assign interruptOutN = state_q.intOutN;
    assign watchdogFaultN = ~state_q.wdFault;
    assign mainRegEnable = state_q.regEn;
    assign auxRegulatorDrive = state_q.auxDrv;
    assign canDriveDominant = state_q.canDom;
    assign canRxd = state_q.rxd;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_can_tx_map: assert property (
        (state_q.mode == sbcsup_pkg::MODE_NORMAL && state_q.canMode == sbcsup_pkg::CAN_NORMAL && modeWr == 1'b0
         && !wbWr && !txdF && !vddUvF && !wdTrig && state_q.wdCnt < wdPeriod - 24'h000001) |=> canDriveDominant)
        else $error("low txd did not drive the bus dominant");
    a_rxd_map: assert property (
        (state_q.canMode != sbcsup_pkg::CAN_OFF && !wbWr) |=> (canRxd == !$past(busDomF)))
        else $error("rxd does not follow bus state");
    a_temp_flag: assert property (
        $rose(tempWarnF) |-> ##1 state_q.flags[sbcsup_pkg::FLG_TEMP])
        else $error("temperature pre-warning not flagged");
    a_reg_shutdown: assert property (
        tempShutF |=> !mainRegEnable)
        else $error("regulator left on during shutdown temperature");
    a_uv_reset: assert property (
        (vddUvF && state_q.mode != sbcsup_pkg::MODE_SLEEP) |=> (!resetOutLow ##1 !resetOutLow))
        else $error("undervoltage did not hold reset low");
    a_reset_mode: assert property (
        (state_q.mode == sbcsup_pkg::MODE_RESET) == !resetOutLow)
        else $error("reset output disagrees with reset mode");
    a_int_level: assert property (
        (|(state_q.flags & state_q.intEn) && flagClr == 4'h0 && !wbWr && !wbReq) |=> !interruptOutN [*2])
        else $error("enabled pending source left interrupt high");
    a_stop_pulse: assert property (
        (state_q.mode == sbcsup_pkg::MODE_STOP && wakeEvt) |=> (!interruptOutN) [*8])
        else $error("stop wake pulse missing");
    a_wd_fault: assert property (
        $rose(state_q.wdFault) |-> (!resetOutLow && !watchdogFaultN))
        else $error("watchdog fault without reset");
    a_bus_ack: assert property (
        (wbReq && !ack_o) |=> (ack_o ##1 !ack_o))
        else $error("bus acknowledge not a single cycle");
endmodule : sbcsup_pin_logic

`default_nettype wire

// [sbcsup_pkg.sv]
`default_nettype none

package sbcsup_pkg;
    // timing base
    localparam int unsigned CLK_KHZ = 25000;
    localparam int unsigned RST_DUR_MS = 15;
    localparam int unsigned RST_DUR_CYC = RST_DUR_MS * CLK_KHZ;
    localparam int unsigned WAKE_PULSE_US = 10;
    localparam int unsigned WAKE_PULSE_CYC = (WAKE_PULSE_US * CLK_KHZ) / 1000;
    localparam int unsigned WD_BASE_MS = 10;
    localparam int unsigned WD_BASE_CYC = WD_BASE_MS * CLK_KHZ;

    // register byte offsets
    localparam logic [7:0] ADR_MODE = 8'h00;
    localparam logic [7:0] ADR_WDCFG = 8'h04;
    localparam logic [7:0] ADR_WDTRIG = 8'h08;
    localparam logic [7:0] ADR_INTEN = 8'h0C;
    localparam logic [7:0] ADR_INTFLAG = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    localparam logic [7:0] ADR_CANCFG = 8'h18;

    // field positions
    localparam int WDCFG_WINDOW_BIT = 0;
    localparam int WDCFG_SEL_LSB = 1;
    localparam int ST_WAKE_LSB = 0;
    localparam int ST_TWARN_BIT = 4;
    localparam int ST_BLOW_BIT = 5;
    localparam int ST_VDDUV_BIT = 6;
    localparam int ST_WDFAULT_BIT = 7;
    localparam int FLG_TEMP = 0;
    localparam int FLG_BATLOW = 1;
    localparam int FLG_WAKE = 2;
    localparam int FLG_BATFAIL = 3;

    // filtered pin vector layout
    localparam int PIN_COUNT = 11;
    localparam int PIN_WAKE_LSB = 0;
    localparam int PIN_VDDUV = 4;
    localparam int PIN_TWARN = 5;
    localparam int PIN_TSHUT = 6;
    localparam int PIN_BFAIL = 7;
    localparam int PIN_BLOW = 8;
    localparam int PIN_TXD = 9;
    localparam int PIN_BUSDOM = 10;
    localparam logic [PIN_COUNT-1:0] PIN_RST = 11'h200;

    // mode request codes written to the mode register
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_STANDBY = 2'h1;
    localparam logic [1:0] REQ_STOP = 2'h2;
    localparam logic [1:0] REQ_SLEEP = 2'h3;

    typedef enum logic [2:0] {
        MODE_RESET, MODE_NREQ, MODE_NORMAL, MODE_STANDBY, MODE_STOP, MODE_SLEEP
    } sbcsup_mode_t;

    typedef enum logic [1:0] {CAN_OFF, CAN_RXONLY, CAN_NORMAL, CAN_SPARE} sbcsup_can_t;

    // reset values
    localparam logic [3:0] INTEN_RST = 4'h0;
    localparam logic WDCFG_WINDOW_RST = 1'b0;
    localparam logic [1:0] WDCFG_SEL_RST = 2'h0;
    localparam sbcsup_can_t CANCFG_RST = CAN_OFF;
endpackage : sbcsup_pkg

`default_nettype wire

// [sbcsup_pin_if.sv]
`default_nettype none

interface sbcsup_pin_if;
    logic [sbcsup_pkg::PIN_COUNT-1:0] raw;
    logic [sbcsup_pkg::PIN_COUNT-1:0] filt;
    modport core (output raw, input filt);
    modport filter (input raw, output filt);
endinterface : sbcsup_pin_if

`default_nettype wire

// [sbcsup_pin_filter.sv]
`default_nettype none

module sbcsup_pin_filter (
    input wire logic ref_clk,
    input wire logic rst_n,
    sbcsup_pin_if.filter pins
);
    localparam int W = sbcsup_pkg::PIN_COUNT;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } sbcsup_filt_t;

    sbcsup_filt_t state_q;
    sbcsup_filt_t state_d;
    logic [W-1:0] agreeNext;
    logic [W-1:0] agreeMask;

    // a bit moves only once stages two and three agree
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            assign agreeMask[i] = ~(state_q.s2[i] ^ state_q.s3[i]);
            assign agreeNext[i] = agreeMask[i] ? state_q.s3[i] : state_q.filt[i];
        end
    endgenerate

    // shift chain, first stage read only by the second
    always_comb begin
        state_d = state_q;
        state_d.s1 = pins.raw;
        state_d.s2 = state_q.s1;
        state_d.s3 = state_q.s2;
        state_d.filt = agreeNext;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '{s1: sbcsup_pkg::PIN_RST, s2: sbcsup_pkg::PIN_RST,
                         s3: sbcsup_pkg::PIN_RST, filt: sbcsup_pkg::PIN_RST};
        end else begin
            state_q <= state_d;
        end
    end

    assign pins.filt = state_q.filt;

    // filtered bits change only where the late stages agreed
    a_filter_agree: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((state_q.filt ^ $past(state_q.filt)) & ~$past(agreeMask)) == '0)
        else $error("filtered pin changed without stage agreement");
endmodule : sbcsup_pin_filter

`default_nettype wire

// [sbcsup_host_model.sv]
`default_nettype none

module sbcsup_host_model (
    input wire logic ref_clk,
    input wire logic ackI,
    output logic cycO,
    output logic stbO,
    output logic weO,
    output logic [7:0] adrO,
    output logic [3:0] selO,
    output logic [31:0] datO,
    output logic canTxd
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus and recessive transmit at time zero
    initial begin
        {cycO, stbO, weO} = 3'h0;
        adrO = 8'h00;
        selO = 4'h0;
        datO = 32'h0;
        canTxd = 1'b1;
    end

    // one classic cycle, held until ack is seen at a rising edge
    task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        cycO <= 1'b1;
        stbO <= 1'b1;
        weO <= w;
        adrO <= a;
        selO <= 4'hF;
        datO <= d;
        do begin
            @(posedge ref_clk);
        end while (ackI !== 1'b1);
        cycO <= 1'b0;
        stbO <= 1'b0;
        weO <= 1'b0;
        adrO <= ~a;
        datO <= ~d;
        @(posedge ref_clk);
    endtask : wbXfer

    // transmit level, changed just after a rising edge
    task automatic txd(input logic v);
        canTxd <= v;
    endtask : txd
endmodule : sbcsup_host_model

`default_nettype wire

// [sbcsup_pin_logic_tb_top.sv]
`default_nettype none

module sbcsup_pin_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST_CYC = 20;
    logic ref_clk, rst_n, cycI, stbI, weI, ackO, canTxd, canBusDominant, vddUnderVolt, tempWarnHot;
    logic tempShutdownHot, batterySupplyFail, batterySupplyLow, canDriveDominant, canRxd, resetOutLow;
    logic interruptOutN, watchdogFaultN, mainRegEnable, auxRegulatorDrive, t;
    logic [7:0] adrI;
    logic [3:0] selI, wakeInputs, w;
    logic [31:0] datI, datO;
    logic [31:0] expQ[$];
    int errTotal = 0;
    int totalChecks = 0;
    int cycles = 0;
    int n;

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    sbcsup_pin_logic #(.RST_DUR_CYC(RST_CYC), .WD_BASE_CYC(40)) sbcsup_pin_logic_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
        .sel_i(selI), .dat_i(datI), .dat_o(datO), .ack_o(ackO), .canTxd(canTxd),
        .canBusDominant(canBusDominant), .vddUnderVolt(vddUnderVolt), .tempWarnHot(tempWarnHot),
        .tempShutdownHot(tempShutdownHot), .batterySupplyFail(batterySupplyFail),
        .batterySupplyLow(batterySupplyLow), .wakeInputs(wakeInputs), .canDriveDominant(canDriveDominant),
        .canRxd(canRxd), .resetOutLow(resetOutLow), .interruptOutN(interruptOutN),
        .watchdogFaultN(watchdogFaultN), .mainRegEnable(mainRegEnable), .auxRegulatorDrive(auxRegulatorDrive));

    sbcsup_host_model sbcsup_host_model_inst (
        .ref_clk(ref_clk), .ackI(ackO), .cycO(cycI), .stbO(stbI), .weO(weI), .adrO(adrI), .selO(selI),
        .datO(datI), .canTxd(canTxd));

    task automatic printVerdict;
        if (errTotal == 0 && totalChecks > 0 && expQ.size() == 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : printVerdict

    task automatic chkBus(input logic [31:0] e, input logic [31:0] s);
        totalChecks++;
        if (s !== e) begin
            errTotal++;
            $display("Error read data expected %h seen %h", e, s);
        end
    endtask : chkBus

    task automatic chkPin(input string nm, input logic e, input logic s);
        totalChecks++;
        if (s !== e) begin
            errTotal++;
            $display("Error %s expected %b seen %b", nm, e, s);
        end
    endtask : chkPin

    // cycle ceiling cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            printVerdict();
        end
    end

    // read answers are matched against the oldest noted expectation
    always @(posedge ref_clk) begin
        if (ackO === 1'b1 && weI === 1'b0)
            chkBus(expQ.size() > 0 ? expQ.pop_front() : 32'hDEAD_BEEF, datO);
    end

    task automatic settle(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sbcsup_host_model_inst.wbXfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        sbcsup_host_model_inst.wbXfer(1'b0, a, 32'h0);
    endtask : rd

    // cycles until the reset pin is released
    task automatic waitReset(output int c);
        c = 0;
        while (resetOutLow !== 1'b1 && c < 200) begin
            @(posedge ref_clk);
            c++;
        end
    endtask : waitReset

    // main sequence
    initial begin
        rst_n = 1'b0;
        {canBusDominant, vddUnderVolt, tempWarnHot, tempShutdownHot} = 4'h0;
        {batterySupplyFail, batterySupplyLow} = 2'h0;
        wakeInputs = 4'h0;
        void'($urandom(99));
        settle(16);
        rst_n <= 1'b1;
        waitReset(n);
        chkPin("reset duration", 1'b1, n >= RST_CYC && n <= RST_CYC + 6);
        rd(sbcsup_pkg::ADR_MODE, 32'h1);
        rd(sbcsup_pkg::ADR_INTEN, {28'h0, sbcsup_pkg::INTEN_RST});
        rd(8'h1C, 32'h0);
        // enabled temperature flag holds interrupt until cleared
        wr(sbcsup_pkg::ADR_INTEN, 32'h1);
        tempWarnHot <= 1'b1;
        settle(8);
        chkPin("interrupt", 1'b0, interruptOutN);
        rd(sbcsup_pkg::ADR_STATUS, 32'h10);
        tempWarnHot <= 1'b0;
        settle(8);
        chkPin("interrupt held", 1'b0, interruptOutN);
        wr(sbcsup_pkg::ADR_INTFLAG, 32'h1);
        settle(2);
        chkPin("interrupt cleared", 1'b1, interruptOutN);
        tempShutdownHot <= 1'b1;
        settle(8);
        chkPin("main regulator", 1'b0, mainRegEnable);
        tempShutdownHot <= 1'b0;
        {batterySupplyFail, batterySupplyLow} <= 2'h3;
        settle(8);
        chkPin("main regulator back", 1'b1, mainRegEnable);
        rd(sbcsup_pkg::ADR_STATUS, 32'h20);
        rd(sbcsup_pkg::ADR_INTFLAG, 32'h8);
        {batterySupplyFail, batterySupplyLow} <= 2'h0;
        wr(sbcsup_pkg::ADR_INTFLAG, 32'hF);
        // window watchdog: an early trigger is a fault
        wr(sbcsup_pkg::ADR_WDCFG, 32'h1);
        wr(sbcsup_pkg::ADR_MODE, {30'h0, sbcsup_pkg::REQ_NORMAL});
        wr(sbcsup_pkg::ADR_WDTRIG, $urandom);
        settle(2);
        chkPin("watchdog fault", 1'b0, watchdogFaultN);
        chkPin("reset on fault", 1'b0, resetOutLow);
        waitReset(n);
        wr(sbcsup_pkg::ADR_WDCFG, 32'h6);
        wr(sbcsup_pkg::ADR_MODE, {30'h0, sbcsup_pkg::REQ_NORMAL});
        wr(sbcsup_pkg::ADR_WDTRIG, $urandom);
        settle(2);
        chkPin("fault cleared", 1'b1, watchdogFaultN);
        rd(sbcsup_pkg::ADR_MODE, 32'h2);
        chkPin("aux regulator", 1'b1, auxRegulatorDrive);
        // transmit and receive mapping under CAN configuration
        wr(sbcsup_pkg::ADR_CANCFG, 32'h2);
        repeat (4) begin
            t = 1'($urandom % 2);
            sbcsup_host_model_inst.txd(t);
            settle(8);
            chkPin("bus drive", ~t, canDriveDominant);
        end
        sbcsup_host_model_inst.txd(1'b1);
        canBusDominant <= 1'b1;
        settle(8);
        chkPin("receive", 1'b0, canRxd);
        canBusDominant <= 1'b0;
        settle(8);
        chkPin("receive recessive", 1'b1, canRxd);
        wr(sbcsup_pkg::ADR_CANCFG, 32'h1);
        sbcsup_host_model_inst.txd(1'b0);
        canBusDominant <= 1'b1;
        settle(8);
        chkPin("receive only", 1'b0, canRxd);
        chkPin("receive only drive", 1'b0, canDriveDominant);
        sbcsup_host_model_inst.txd(1'b1);
        wr(sbcsup_pkg::ADR_CANCFG, 32'h0);
        settle(8);
        chkPin("receive off", 1'b1, canRxd);
        canBusDominant <= 1'b0;
        // timeout watchdog with period 40 << 3
        wr(sbcsup_pkg::ADR_WDTRIG, $urandom);
        n = 0;
        while (watchdogFaultN === 1'b1 && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
        chkPin("timeout", 1'b1, n >= 318 && n <= 326);
        chkPin("timeout reset", 1'b0, resetOutLow);
        waitReset(n);
        vddUnderVolt <= 1'b1;
        settle(8);
        chkPin("undervoltage reset", 1'b0, resetOutLow);
        vddUnderVolt <= 1'b0;
        waitReset(n);
        chkPin("undervoltage release", 1'b1, resetOutLow);
        // stop mode wake gives one fixed-width pulse
        wr(sbcsup_pkg::ADR_MODE, {30'h0, sbcsup_pkg::REQ_NORMAL});
        wr(sbcsup_pkg::ADR_WDTRIG, $urandom);
        wr(sbcsup_pkg::ADR_MODE, {30'h0, sbcsup_pkg::REQ_STOP});
        w = 4'h1 << ($urandom % 4);
        wakeInputs <= w;
        n = 0;
        while (interruptOutN === 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (interruptOutN === 1'b0 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chkPin("wake pulse", 1'b1, n == sbcsup_pkg::WAKE_PULSE_CYC);
        rd(sbcsup_pkg::ADR_MODE, 32'h1);
        rd(sbcsup_pkg::ADR_STATUS, {28'h0, w});
        chkPin("aux regulator off", 1'b0, auxRegulatorDrive);
        // standby, then sleep, then a wake change back through reset
        wr(sbcsup_pkg::ADR_MODE, {30'h0, sbcsup_pkg::REQ_STANDBY});
        rd(sbcsup_pkg::ADR_MODE, 32'h3);
        chkPin("aux regulator standby", 1'b0, auxRegulatorDrive);
        wr(sbcsup_pkg::ADR_MODE, {30'h0, sbcsup_pkg::REQ_SLEEP});
        settle(2);
        chkPin("sleep regulator", 1'b0, mainRegEnable);
        wakeInputs <= ~w;
        settle(8);
        chkPin("sleep wake reset", 1'b0, resetOutLow);
        waitReset(n);
        chkPin("sleep wake release", 1'b1, resetOutLow);
        settle(4);
        printVerdict();
    end
endmodule : sbcsup_pin_logic_tb_top

`default_nettype wire
